// ### sim/xefs_board.sv
`timescale 1ns/1ps

// control board side: jumper, contacts and collector pull-ups
module xefs_board (
  // settings from the bench
  input  wire logic               ilk_closed,
  input  wire logic               on_req,
  input  wire logic               remote,
  // collector drive from the device
  input  wire xefs_pkg::xefs_oc_t oc_out,
  input  wire xefs_pkg::xefs_oc_t oc_oe,
  // pins into the device
  output logic                    jumper,
  output logic                    ilk_n,
  output logic                    contact_n,
  // collector lines as the board sees them
  output xefs_pkg::xefs_oc_t      pin
);
  // jumper 1-2 grounds the select pin, 2-3 pulls it up
  assign jumper = remote;
  // an open loop floats high, so open reads as not safe
  assign ilk_n = !ilk_closed;
  // open contact relies on the pull-up and reads off
  assign contact_n = !on_req;
  // board pull-up wins unless the device sinks the line
  assign pin = (oc_oe & oc_out) | ~oc_oe;
endmodule

// ### sim/xefs_top_tb_top.sv
`timescale 1ns/1ps
`include "xefs_defs.svh"

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module xefs_top_tb_top;
  // clock, reset and apb
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  // board settings and supply detectors
  logic               ilk_cl = 1'b0, on_req = 1'b0, remote = 1'b0;
  logic               arc = 1'b0, flim = 1'b0, fstb = 1'b0, rlost = 1'b0;
  logic [10:0]        kv_mon = 11'h12C, kv_prg = 11'h12C;
  logic [9:0]         ua_mon = 10'h064, ua_prg = 10'h064;
  logic [7:0]         temp = 8'h19;
  // device outputs and pins
  logic               jumper, ilk_n, contact_n, hv;
  logic [10:0]        kv_sp;
  logic [9:0]         ua_sp;
  xefs_pkg::xefs_oc_t oc_out, oc_oe, pin;
  logic [31:0]        rd;
  logic               er;
  int                 mismatches = 0, checks_done = 0, cyc = 0;

  always #2 clk = ~clk;

  // short debounce and watchdog keep the run brief
  xefs_top #(.DEBOUNCE_CYC(32'h4), .WDOG_CYC(32'h32), .OPTION_50W(1'b0)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MODE_SELECT_JUMPER(jumper), .INTERLOCK_INPUT_N(ilk_n),
    .XRAY_ON_CONTACT_INPUT_N(contact_n), .ARC_DETECT(arc),
    .FILAMENT_OVER_LIMIT(flim), .FILAMENT_IN_STANDBY(fstb),
    .REGULATION_LOST(rlost), .KV_MONITOR(kv_mon), .UA_MONITOR(ua_mon),
    .KV_PROGRAM(kv_prg), .UA_PROGRAM(ua_prg), .OIL_TEMP_C(temp),
    .HV_ENABLE(hv), .KV_SETPOINT(kv_sp), .UA_SETPOINT(ua_sp),
    .OC_OUT(oc_out), .OC_OE(oc_oe));

  xefs_board i_board (
    .ilk_closed(ilk_cl), .on_req(on_req), .remote(remote), .oc_out(oc_out),
    .oc_oe(oc_oe), .jumper(jumper), .ilk_n(ilk_n), .contact_n(contact_n),
    .pin(pin));

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // read a register and compare the whole word
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    wt(8);
    arst_n <= 1'b1;
    wt(2);
    rchk(`XEFS_ADDR_KV_SET, 32'h15E);
    rchk(`XEFS_ADDR_UA_SET, 32'h0);
    rchk(8'h40, 32'h0);
    `CHK(er, 1'b1)
    tend("reset");
    // local on request while the loop is open
    on_req <= 1'b1;
    wt(20);
    `CHK(hv, 1'b0)
    `CHK(pin.ilk, 1'b1)
    `CHK(oc_oe.ready, 1'b0)
    rchk(`XEFS_ADDR_CODE, 32'h9);
    ilk_cl <= 1'b1;
    wt(20);
    `CHK(hv, 1'b1)
    `CHK(pin.ilk, 1'b0)
    `CHK(oc_oe.ready, 1'b1)
    `CHK(pin.xon, 1'b0)
    `CHK(oc_out, 9'h0)
    rchk(`XEFS_ADDR_CODE, 32'h100);
    rchk(`XEFS_ADDR_MON, 32'h0064012C);
    `CHK(ua_sp, 10'h064)
    // a glitch shorter than the debounce is ignored
    ilk_cl <= 1'b0;
    wt(2);
    ilk_cl <= 1'b1;
    wt(20);
    `CHK(hv, 1'b1)
    ilk_cl <= 1'b0;
    wt(20);
    `CHK(hv, 1'b0)
    ilk_cl <= 1'b1;
    wt(20);
    tend("interlock");
    // 82 kV itself is allowed, one step above trips and latches
    kv_mon <= 11'h334;
    wt(4);
    `CHK(hv, 1'b1)
    kv_mon <= 11'h335;
    wt(4);
    kv_mon <= 11'h12C;
    wt(4);
    `CHK(hv, 1'b0)
    `CHK(oc_oe.ov, 1'b1)
    `CHK(oc_oe.ready, 1'b0)
    rchk(`XEFS_ADDR_CODE, 32'h6);
    on_req <= 1'b0;
    wt(20);
    on_req <= 1'b1;
    wt(20);
    `CHK(oc_oe.ov, 1'b0)
    `CHK(hv, 1'b1)
    tend("local clear");
    // remote: contact has no effect, host switches
    on_req <= 1'b0;
    wt(20);
    remote <= 1'b1;
    on_req <= 1'b1;
    ua_mon <= 10'h113;
    wt(20);
    `CHK(hv, 1'b0)
    `CHK(kv_sp, 11'h15E)
    rchk(`XEFS_ADDR_STATUS, 32'hA80);
    apb(1'b1, `XEFS_ADDR_UA_SET, 32'h113);
    apb(1'b1, `XEFS_ADDR_CTRL, 32'h1);
    wt(2);
    `CHK(hv, 1'b1)
    `CHK(ua_sp, 10'h113)
    arc <= 1'b1;
    wt(3);
    arc <= 1'b0;
    wt(6);
    `CHK(hv, 1'b0)
    `CHK(oc_oe.arc, 1'b1)
    rchk(`XEFS_ADDR_CODE, 32'h2);
    apb(1'b1, `XEFS_ADDR_CMD, 32'h34);
    rchk(`XEFS_ADDR_CODE, 32'h0);
    `CHK(oc_oe.arc, 1'b0)
    apb(1'b1, `XEFS_ADDR_CTRL, 32'h1);
    ua_mon <= 10'h114;
    wt(6);
    ua_mon <= 10'h113;
    `CHK(oc_oe.oc, 1'b1)
    rchk(`XEFS_ADDR_CODE, 32'h3);
    apb(1'b1, `XEFS_ADDR_CMD, 32'h34);
    tend("remote");
    // watchdog holds for 50 silent cycles, then trips
    apb(1'b1, `XEFS_ADDR_CTRL, 32'h3);
    wt(40);
    `CHK(hv, 1'b1)
    wt(20);
    `CHK(hv, 1'b0)
    rchk(`XEFS_ADDR_CODE, 32'h7);
    apb(1'b1, `XEFS_ADDR_CMD, 32'h34);
    apb(1'b1, `XEFS_ADDR_CTRL, 32'h1);
    // lost regulation below 35 kV drives no fault or standby line
    rlost <= 1'b1;
    wt(6);
    rlost <= 1'b0;
    `CHK(hv, 1'b0)
    `CHK(oc_oe[8:3], 6'h0)
    rchk(`XEFS_ADDR_CODE, 32'h4);
    apb(1'b1, `XEFS_ADDR_CMD, 32'h34);
    flim <= 1'b1;
    wt(6);
    flim <= 1'b0;
    `CHK(oc_oe.flim, 1'b1)
    rchk(`XEFS_ADDR_CODE, 32'hA);
    apb(1'b1, `XEFS_ADDR_CMD, 32'h34);
    fstb <= 1'b1;
    wt(6);
    `CHK(oc_oe.fstby, 1'b1)
    rchk(`XEFS_ADDR_CODE, 32'hB);
    fstb <= 1'b0;
    temp <= 8'h41;
    wt(4);
    `CHK(oc_oe.otemp, 1'b0)
    temp <= 8'h42;
    wt(4);
    `CHK(oc_oe.otemp, 1'b1)
    tend("faults");
    close_out();
  end
endmodule

// ### verilog/xefs_defs.svh
`ifndef XEFS_DEFS_SVH
`define XEFS_DEFS_SVH

// register byte offsets on the apb slave
`define XEFS_ADDR_CTRL      8'h00
`define XEFS_ADDR_CMD       8'h04
`define XEFS_ADDR_KV_SET    8'h08
`define XEFS_ADDR_UA_SET    8'h0C
`define XEFS_ADDR_STATUS    8'h10
`define XEFS_ADDR_CODE      8'h14
`define XEFS_ADDR_MON       8'h18

// control register field positions
`define XEFS_CTRL_ON_BIT    0
`define XEFS_CTRL_WDEN_BIT  1

// host commands
`define XEFS_CMD_RESET_FLT  8'h34

// scales: voltage in 100 V steps, full scale 80 kV; current in uA
`define XEFS_KV_FULL_SCALE  11'h320
`define XEFS_KV_RESET       11'h15E
`define XEFS_UA_RESET       10'h000
`define XEFS_KV_OV_LIM      11'h334
`define XEFS_KV_UV_LIM      11'h15E
`define XEFS_UA_LIM_LO      10'h113
`define XEFS_UA_LIM_HI      10'h2C6
`define XEFS_UA_ERR_PCT     8'h0A
`define XEFS_TEMP_LIM_C     8'h41

// host status codes
`define XEFS_CODE_READY     4'h0
`define XEFS_CODE_XON       4'h1
`define XEFS_CODE_ARC       4'h2
`define XEFS_CODE_OC        4'h3
`define XEFS_CODE_UV        4'h4
`define XEFS_CODE_OV        4'h6
`define XEFS_CODE_WDOG      4'h7
`define XEFS_CODE_ILK       4'h9
`define XEFS_CODE_FLIM      4'hA
`define XEFS_CODE_FSTBY     4'hB

// timing: clock in MHz, debounce in us, watchdog in s
`define XEFS_CLK_MHZ        64'hFA
`define XEFS_DEB_US         64'h3E8
`define XEFS_WDOG_S         64'hA
`define XEFS_DEB_CYC        (`XEFS_DEB_US * `XEFS_CLK_MHZ)
`define XEFS_WDOG_CYC       (`XEFS_WDOG_S * 64'hF4240 * `XEFS_CLK_MHZ)

`endif

// ### verilog/xefs_pkg.sv
package xefs_pkg;

  // latched fault flags
  typedef struct packed {
    logic otemp;
    logic wdog;
    logic flim;
    logic uv;
    logic arc;
    logic oc;
    logic ov;
  } xefs_flt_t;

  // open-collector outputs, one enable bit each
  typedef struct packed {
    logic otemp;
    logic flim;
    logic arc;
    logic oc;
    logic ov;
    logic fstby;
    logic xon;
    logic ready;
    logic ilk;
  } xefs_oc_t;

  // whole state of the supervisor
  typedef struct packed {
    logic [2:0]  ilk_s;
    logic [2:0]  cmd_s;
    logic [2:0]  arc_s;
    logic [2:0]  flim_s;
    logic [2:0]  fstb_s;
    logic [2:0]  mode_s;
    logic [2:0]  lreg_s;
    logic        ilk_db;
    logic        cmd_db;
    logic [31:0] ilk_cnt;
    logic [31:0] cmd_cnt;
    logic [31:0] wd_cnt;
    logic        remote;
    logic        on_req;
    logic        wd_en;
    logic [10:0] kv_set;
    logic [9:0]  ua_set;
    logic [10:0] kv_out;
    logic [9:0]  ua_out;
    xefs_flt_t   flt;
    logic        hv;
    xefs_oc_t    oe;
    xefs_oc_t    lvl;
    logic [3:0]  code;
    logic        xon_code;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } xefs_state_t;

endpackage

// ### verilog/xefs_top.sv
`timescale 1ns/1ps
`include "xefs_defs.svh"

// Overview of operation
// - jumper low picks local pin control, jumper high picks remote host control
// - after reset setpoints are zero except voltage, which starts at 35 kV
// - voltage scale is linear with 80 kV full scale; current linear too
// - local: contact input switches x-ray; remote: only host command does
// - high voltage is never enabled while the interlock is open
// - interlock opening while high voltage runs turns it off at once
// - any fault powers down, drops high voltage, reports not ready
// - host clears all latched faults by sending command 52
// - every status or fault output is open collector, pulled low when active
// - open interlock reports code 9; interlock output low when closed
// - ready output low only with no fault and interlock closed; code 0 also shows with over-temperature alone
// - x-ray on reported as bit 8 of the code register and output low while on
// - output above 82 kV trips, pulls overvoltage low, code 6
// - current above limit or too far from setpoint trips, code 3
// - one arc trips and latches the arc fault, code 2
// - lost regulation below 35 kV trips, code 4, no discrete output
// - filament current over limit pulls its output low, code 10
// - x-ray off with filament in standby pulls standby low, code 11
// - enabled watchdog faults with code 7 after ten silent seconds
// - oil temperature above 65 C pulls over-temperature low
module xefs_top #(
  parameter logic [31:0] DEBOUNCE_CYC = 32'(`XEFS_DEB_CYC),
  parameter logic [31:0] WDOG_CYC     = 32'(`XEFS_WDOG_CYC),
  parameter bit          OPTION_50W   = 1'b0
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // pins from the connector and the jumper
  input  wire logic        MODE_SELECT_JUMPER,
  input  wire logic        INTERLOCK_INPUT_N,
  input  wire logic        XRAY_ON_CONTACT_INPUT_N,
  // detectors from the supply
  input  wire logic        ARC_DETECT,
  input  wire logic        FILAMENT_OVER_LIMIT,
  input  wire logic        FILAMENT_IN_STANDBY,
  input  wire logic        REGULATION_LOST,
  // digitised measurements and local programs, same clock
  input  wire logic [10:0] KV_MONITOR,
  input  wire logic [9:0]  UA_MONITOR,
  input  wire logic [10:0] KV_PROGRAM,
  input  wire logic [9:0]  UA_PROGRAM,
  input  wire logic [7:0]  OIL_TEMP_C,
  // drive to the high voltage supply
  output logic             HV_ENABLE,
  output logic [10:0]      KV_SETPOINT,
  output logic [9:0]       UA_SETPOINT,
  // open-collector status outputs
  output xefs_pkg::xefs_oc_t OC_OUT,
  output xefs_pkg::xefs_oc_t OC_OE
);

  xefs_pkg::xefs_state_t s_r;
  xefs_pkg::xefs_state_t s_nxt;
  xefs_pkg::xefs_flt_t   flt_set;
  logic                  flt_clr;
  logic                  ilk_ok;
  logic                  cmd_ok;
  logic                  apb_setup;
  logic                  apb_done;
  logic                  apb_wr;
  logic                  on_cmd;
  logic                  stby;
  logic [9:0]            ua_diff;
  logic [9:0]            ua_lim;
  logic [33:0]           deb_i;
  logic [33:0]           deb_c;

  // debounce step: result is {level, changed, count}
  // any disagreement or a return to the old level restarts the count from zero
  function automatic logic [33:0] deb_step(input logic raw, input logic agree,
                                           input logic lvl, input logic [31:0] cnt);
    logic [33:0] r;
    r = {lvl, 1'b0, 32'h0000_0000};
    if (agree && raw != lvl) begin
      if (cnt >= DEBOUNCE_CYC - 32'h0000_0001) begin
        r = {raw, 1'b1, 32'h0000_0000};
      end else begin
        r = {lvl, 1'b0, cnt + 32'h0000_0001};
      end
    end
    return r;
  endfunction

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // three-stage synchronisers; stage 0 feeds stage 1 only
    // jumper and detector pins share this path; only interlock and contact are debounced
    s_nxt.ilk_s  = {s_r.ilk_s[1:0], INTERLOCK_INPUT_N};
    s_nxt.cmd_s  = {s_r.cmd_s[1:0], XRAY_ON_CONTACT_INPUT_N};
    s_nxt.arc_s  = {s_r.arc_s[1:0], ARC_DETECT};
    s_nxt.flim_s = {s_r.flim_s[1:0], FILAMENT_OVER_LIMIT};
    s_nxt.fstb_s = {s_r.fstb_s[1:0], FILAMENT_IN_STANDBY};
    s_nxt.mode_s = {s_r.mode_s[1:0], MODE_SELECT_JUMPER};
    s_nxt.lreg_s = {s_r.lreg_s[1:0], REGULATION_LOST};

    // both pins are active low: low means closed / on
    ilk_ok = s_r.ilk_s[1] == s_r.ilk_s[2];
    cmd_ok = s_r.cmd_s[1] == s_r.cmd_s[2];
    deb_i = deb_step(~s_r.ilk_s[2], ilk_ok, s_r.ilk_db, s_r.ilk_cnt);
    deb_c = deb_step(~s_r.cmd_s[2], cmd_ok, s_r.cmd_db, s_r.cmd_cnt);
    s_nxt.ilk_db  = deb_i[33];
    s_nxt.ilk_cnt = deb_i[31:0];
    s_nxt.cmd_db  = deb_c[33];
    s_nxt.cmd_cnt = deb_c[31:0];

    // jumper is static; a change counts once stages agree
    if (s_r.mode_s[1] == s_r.mode_s[2]) begin
      s_nxt.remote = s_r.mode_s[2];
    end

    // standby is worked out before the status read below, which shows it
    stby      = !s_r.hv && s_r.fstb_s[1] && s_r.fstb_s[2];

    // apb phases; the slave answers with no wait state
    apb_setup = PSEL && !PENABLE;
    apb_done  = PSEL && PENABLE && s_r.pready;
    apb_wr    = apb_done && PWRITE;
    s_nxt.pready  = apb_setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = 32'h0000_0000;
    if (apb_setup) begin
      case (PADDR)
        `XEFS_ADDR_CTRL:   s_nxt.prdata = {30'h0000_0000, s_r.wd_en, s_r.on_req};
        `XEFS_ADDR_CMD:    s_nxt.prdata = 32'h0000_0000;
        `XEFS_ADDR_KV_SET: s_nxt.prdata = {21'h00_0000, s_r.kv_set};
        `XEFS_ADDR_UA_SET: s_nxt.prdata = {22'h00_0000, s_r.ua_set};
        `XEFS_ADDR_STATUS: s_nxt.prdata = {20'h0_0000, s_r.remote, s_r.hv, s_r.ilk_db,
                                           stby, s_r.oe.ready, s_r.flt};
        `XEFS_ADDR_CODE:   s_nxt.prdata = {23'h00_0000, s_r.xon_code, 4'h0, s_r.code};
        `XEFS_ADDR_MON:    s_nxt.prdata = {6'h00, UA_MONITOR, 5'h00, KV_MONITOR};
        default:           s_nxt.pslverr = 1'b1; // unmapped address
      endcase
    end

    // watchdog: any completed host access counts as communication
    // the count saturates, so a long silence can never wrap and hide the fault
    if (!s_r.wd_en || apb_done) begin
      s_nxt.wd_cnt = 32'h0000_0000;
    end else if (s_r.wd_cnt < WDOG_CYC) begin
      s_nxt.wd_cnt = s_r.wd_cnt + 32'h0000_0001;
    end

    // fault detectors
    // the current error check runs only with high voltage on: the supply cannot track while off
    ua_lim  = OPTION_50W ? `XEFS_UA_LIM_HI : `XEFS_UA_LIM_LO;
    ua_diff = (UA_MONITOR > s_r.ua_out) ? UA_MONITOR - s_r.ua_out : s_r.ua_out - UA_MONITOR;
    flt_set.ov    = KV_MONITOR > `XEFS_KV_OV_LIM;
    flt_set.oc    = (UA_MONITOR > ua_lim) ||
                    (s_r.hv && ({8'h00, ua_diff} * 18'h00064 >
                                {10'h000, `XEFS_UA_ERR_PCT} * {8'h00, s_r.ua_out}));
    flt_set.arc   = s_r.arc_s[1] && s_r.arc_s[2];
    flt_set.uv    = s_r.hv && s_r.lreg_s[1] && s_r.lreg_s[2] &&
                    KV_MONITOR < `XEFS_KV_UV_LIM;
    flt_set.flim  = s_r.flim_s[1] && s_r.flim_s[2];
    flt_set.wdog  = s_r.wd_en && s_r.wd_cnt >= WDOG_CYC;
    flt_set.otemp = OIL_TEMP_C > `XEFS_TEMP_LIM_C;

    // clear: local contact off then on, or host command; a set wins
    flt_clr = (!s_r.remote && !s_r.cmd_db && s_nxt.cmd_db) ||
              (apb_wr && PADDR == `XEFS_ADDR_CMD &&
               PWDATA[7:0] == `XEFS_CMD_RESET_FLT);
    s_nxt.flt = (s_r.flt & ~(flt_clr ? 7'h7F : 7'h00)) | flt_set;

    // host registers
    // the on bit is stored in local mode too but only acts once the jumper selects remote
    if (apb_wr && PADDR == `XEFS_ADDR_CTRL) begin
      s_nxt.on_req = PWDATA[`XEFS_CTRL_ON_BIT];
      s_nxt.wd_en  = PWDATA[`XEFS_CTRL_WDEN_BIT];
    end
    if (apb_wr && PADDR == `XEFS_ADDR_KV_SET) begin
      s_nxt.kv_set = PWDATA[10:0];
    end
    if (apb_wr && PADDR == `XEFS_ADDR_UA_SET) begin
      s_nxt.ua_set = PWDATA[9:0];
    end
    // a fault powers down: the host must ask for x-ray again
    if (|flt_set) begin
      s_nxt.on_req = 1'b0;
    end

    // local takes the pin programs, remote the host setpoints; both scale to 80 kV
    s_nxt.kv_out = s_r.remote ? s_r.kv_set : KV_PROGRAM;
    s_nxt.ua_out = s_r.remote ? s_r.ua_set : UA_PROGRAM;

    // x-ray source: contact locally, host command remotely
    on_cmd   = s_r.remote ? s_nxt.on_req : s_nxt.cmd_db;
    // interlock and faults gate in the same cycle they appear
    s_nxt.hv = on_cmd && s_nxt.ilk_db && !(|s_nxt.flt);

    // host status code, most severe first
    // over-temperature has no code of its own; software sees it in the status word
    if (s_nxt.flt.wdog) begin
      s_nxt.code = `XEFS_CODE_WDOG;
    end else if (s_nxt.flt.arc) begin
      s_nxt.code = `XEFS_CODE_ARC;
    end else if (s_nxt.flt.ov) begin
      s_nxt.code = `XEFS_CODE_OV;
    end else if (s_nxt.flt.oc) begin
      s_nxt.code = `XEFS_CODE_OC;
    end else if (s_nxt.flt.uv) begin
      s_nxt.code = `XEFS_CODE_UV;
    end else if (s_nxt.flt.flim) begin
      s_nxt.code = `XEFS_CODE_FLIM;
    end else if (!s_nxt.ilk_db) begin
      s_nxt.code = `XEFS_CODE_ILK;
    end else if (stby) begin
      s_nxt.code = `XEFS_CODE_FSTBY;
    end else begin
      s_nxt.code = `XEFS_CODE_READY;
    end
    s_nxt.xon_code = s_nxt.hv;

    // open collector: level always low, enable pulls while active
    // the pins only sink, so a released line reads high through the board pull-up
    s_nxt.lvl      = '0;
    s_nxt.oe.ilk   = s_nxt.ilk_db;
    s_nxt.oe.ready = !(|s_nxt.flt) && s_nxt.ilk_db;
    s_nxt.oe.xon   = s_nxt.hv;
    s_nxt.oe.fstby = stby;
    s_nxt.oe.ov    = s_nxt.flt.ov;
    s_nxt.oe.oc    = s_nxt.flt.oc;
    s_nxt.oe.arc   = s_nxt.flt.arc;
    s_nxt.oe.flim  = s_nxt.flt.flim;
    s_nxt.oe.otemp = s_nxt.flt.otemp;
  end

  // state register; interlock and contact pins idle high so their synchronisers reset to one
  // a reset in mid-run drops high voltage at once, without waiting for a clock edge
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r         <= '0;
      s_r.ilk_s   <= 3'h7;
      s_r.cmd_s   <= 3'h7;
      s_r.kv_set  <= `XEFS_KV_RESET;
      s_r.ua_set  <= `XEFS_UA_RESET;
      s_r.kv_out  <= `XEFS_KV_RESET;
      s_r.ua_out  <= `XEFS_UA_RESET;
      s_r.code    <= `XEFS_CODE_ILK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign PRDATA      = s_r.prdata;
  assign PREADY      = s_r.pready;
  assign PSLVERR     = s_r.pslverr;
  assign HV_ENABLE   = s_r.hv;
  assign KV_SETPOINT = s_r.kv_out;
  assign UA_SETPOINT = s_r.ua_out;
  assign OC_OUT      = s_r.lvl;
  assign OC_OE       = s_r.oe;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  hv_needs_ilk_a: assert property (s_r.hv |-> s_r.ilk_db)
    else $error("high voltage on with interlock open");
  ilk_open_trip_a: assert property ($fell(s_nxt.ilk_db) |=> !s_r.hv)
    else $error("high voltage survived interlock opening");
  fault_blocks_hv_a: assert property ((|s_r.flt) |-> !s_r.hv && !s_r.oe.ready)
    else $error("fault present but high voltage or ready on");
  ov_trip_a: assert property (KV_MONITOR > `XEFS_KV_OV_LIM |=>
                              s_r.flt.ov && s_r.oe.ov && !s_r.hv)
    else $error("overvoltage not tripped");
  reset_cmd_a: assert property (apb_wr && PADDR == `XEFS_ADDR_CMD &&
                                PWDATA[7:0] == `XEFS_CMD_RESET_FLT && !(|flt_set)
                                |=> s_r.flt == '0)
    else $error("reset faults command did not clear");
  latch_hold_a: assert property (s_r.flt.arc && !flt_clr |=> s_r.flt.arc [*1])
    else $error("arc fault dropped without reset");
  local_follow_a: assert property (!s_r.remote && s_r.remote == $past(s_r.remote) &&
                                   s_nxt.cmd_db && s_nxt.ilk_db && !(|s_nxt.flt)
                                   |=> s_r.hv)
    else $error("local contact did not switch x-ray on");
  ilk_code_a: assert property (!s_r.ilk_db && !(|s_r.flt) |->
                               s_r.code == `XEFS_CODE_ILK && !s_r.oe.ilk)
    else $error("open interlock not reported");
  xon_report_a: assert property (s_r.xon_code == s_r.hv && s_r.oe.xon == s_r.hv)
    else $error("x-ray on report disagrees with high voltage");
  wdog_trip_a: assert property (s_r.wd_en && s_r.wd_cnt >= WDOG_CYC |=>
                                s_r.flt.wdog ##1 s_r.code == `XEFS_CODE_WDOG)
    else $error("watchdog did not fault");
  temp_flag_a: assert property (OIL_TEMP_C > `XEFS_TEMP_LIM_C |=> s_r.oe.otemp)
    else $error("over temperature not flagged");

  // per-rule checks on the registered state; each names the cycle in which
  // the answer must stand, taken from the next-state logic above

  // remote setpoints reach the supply one cycle after they are held
  setpt_route_a: assert property (s_r.remote |=>
                                  s_r.kv_out == $past(s_r.kv_set) &&
                                  s_r.ua_out == $past(s_r.ua_set))
    else $error("remote setpoint not passed to the supply");

  // in remote mode the contact pin alone never raises high voltage
  remote_ignore_a: assert property (s_r.remote && !s_nxt.on_req |=> !s_r.hv)
    else $error("contact switched x-ray in remote mode");

  // a new fault drops the host request and high voltage together
  fault_drops_req_a: assert property ((|flt_set) |=> !s_r.on_req && !s_r.hv)
    else $error("fault left x-ray request or high voltage on");

  // contact turning on again in local mode clears every latched fault
  local_clear_a: assert property (!s_r.remote && !s_r.cmd_db && s_nxt.cmd_db &&
                                  !(|flt_set) |=> s_r.flt == '0)
    else $error("local contact toggle did not clear faults");

  // collector level stays low; only the enables ever move
  oc_level_a: assert property (s_r.lvl == '0)
    else $error("open collector level driven high");

  // interlock pin pulls low exactly while the debounced loop reads closed
  ilk_pin_a: assert property (s_r.oe.ilk == s_r.ilk_db)
    else $error("interlock pin disagrees with the loop");

  // ready without standby shows code 0 to the host
  ready_code_a: assert property (s_r.oe.ready && !s_r.oe.fstby |->
                                 s_r.code == `XEFS_CODE_READY)
    else $error("ready pin and host code disagree");

  // current above the fitted limit trips and latches
  oc_trip_a: assert property (UA_MONITOR > ua_lim |=>
                              s_r.flt.oc && s_r.oe.oc && !s_r.hv)
    else $error("overcurrent not tripped");

  // one arc seen by the synchroniser is enough to latch
  arc_trip_a: assert property (s_r.arc_s[1] && s_r.arc_s[2] |=>
                               s_r.flt.arc && s_r.oe.arc && !s_r.hv)
    else $error("arc not latched");

  // lost regulation at low output trips without a pin of its own
  uv_trip_a: assert property (s_r.hv && s_r.lreg_s[1] && s_r.lreg_s[2] &&
                              KV_MONITOR < `XEFS_KV_UV_LIM |=> s_r.flt.uv && !s_r.hv)
    else $error("lost regulation not tripped");

  // filament over its limit latches and pulls its pin
  flim_trip_a: assert property (s_r.flim_s[1] && s_r.flim_s[2] |=>
                                s_r.flt.flim && s_r.oe.flim && !s_r.hv)
    else $error("filament limit not flagged");

  // standby with x-ray off pulls its pin
  stby_pin_a: assert property (!s_r.hv && s_r.fstb_s[1] && s_r.fstb_s[2] |=>
                               s_r.oe.fstby)
    else $error("filament standby not flagged");

  // a disabled watchdog keeps its counter at rest
  wd_idle_a: assert property (!s_r.wd_en |=> s_r.wd_cnt == 32'h0000_0000)
    else $error("watchdog counting while disabled");

  // no flag drops unless a clear action is seen
  flt_sticky_a: assert property (!flt_clr |=>
                                 (s_r.flt & $past(s_r.flt)) == $past(s_r.flt))
    else $error("fault flag dropped without reset");

endmodule
